// ### pkg/adc_flag_consts.vh
// Purpose: register map, field positions and reset values of the converter flag logic
// Assumes: byte addresses on an 8-bit register port, one 32-bit word per register
// Notes:   included by the flag logic, its checker and its bench
`ifndef ADC_FLAG_CONSTS_VH
`define ADC_FLAG_CONSTS_VH

// ****************************************************************
// geometry
// ****************************************************************
`define NUM_CHAN          8
`define CHAN_IDX_W        3
`define RESULT_W          10
`define ADDR_W            8
`define DATA_W            32
`define IRQ_W             11

// ****************************************************************
// register offsets (bytes)
// ****************************************************************
`define REG_CONTROL       8'h00
`define REG_MODE          8'h04
`define REG_CHAN_ENABLE   8'h10
`define REG_CHAN_DISABLE  8'h14
`define REG_CHAN_STATUS   8'h18
`define REG_STATUS        8'h1c
`define REG_LAST_RESULT   8'h20
`define REG_IRQ_ENABLE    8'h24
`define REG_IRQ_CLEAR     8'h28
`define REG_IRQ_STATUS    8'h2c
// channel result n sits at 8'h40 + 4*n
`define CHAN_RES_HI       3'b010

// ****************************************************************
// field positions
// ****************************************************************
`define CTRL_START_BIT    0
`define MODE_SLEEP_BIT    0
`define ST_DONE_LSB       0
`define ST_OVR_LSB        8
`define ST_RDY_BIT        16
`define ST_GOVR_BIT       17
`define LAST_CHAN_LSB     12
`define IRQ_DONE_LSB      0
`define IRQ_RDY_BIT       8
`define IRQ_OVR_BIT       9
`define IRQ_GOVR_BIT      10

// ****************************************************************
// reset values
// ****************************************************************
`define CHAN_EN_RST       8'h00
`define MODE_RST          1'b0
`define IRQ_EN_RST        11'h000
`define RESULT_RST        10'h000
`define RDATA_RST         32'h0000_0000

`endif

// ### rtl/sticky_flag.v
// Purpose: one status flag that hardware sets and a clear event resets
// Assumes: set and clear are single-cycle, synchronous to ref_clk
// Notes:   set beats clear in the same cycle
`timescale 1ns/100ps
module sticky_flag (
   // clock and reset
   input  wire ref_clk,
   input  wire rst,
   // events
   input  wire set,
   input  wire clr,
   // flag
   output reg  flag_q
);

   wire flag_d;

   assign flag_d = set | (flag_q & ~clr);

   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         flag_q <= 1'b0;
      end else begin
         flag_q <= flag_d;
      end
   end

endmodule

// ### rtl/adc_status_flag_logic.v
// Purpose: status flags, result registers and sleep entry of a converter controller
// Assumes: the conversion core gives a one-cycle end pulse with channel and data
// Notes:   register reads have their clear side effects in the cycle of the read strobe
//
// Chosen here: the plain strobed port and the address map.
`timescale 1ns/100ps
`include "adc_flag_consts.vh"
module adc_status_flag_logic (
   // clock and reset
   input  wire                     ref_clk,
   input  wire                     rst,
   // register port
   input  wire [`ADDR_W-1:0]       reg_addr,
   input  wire [`DATA_W-1:0]       reg_wdata,
   input  wire                     reg_wr,
   input  wire                     reg_rd,
   output reg  [`DATA_W-1:0]       reg_rdata,
   // conversion core
   input  wire                     conv_end,
   input  wire [`CHAN_IDX_W-1:0]   conv_chan,
   input  wire [`RESULT_W-1:0]     conv_data,
   output reg                      conv_start,
   output wire [`NUM_CHAN-1:0]     chan_enable,
   // power and interrupt
   output reg                      sleep_active,
   output wire                     irq
);

   // ****************************************************************
   // decode helpers
   // ****************************************************************
   function [`NUM_CHAN-1:0] onehot;
      input [`CHAN_IDX_W-1:0] idx;
      integer k;
      begin
         onehot = {`NUM_CHAN{1'b0}};
         for (k = 0; k < `NUM_CHAN; k = k + 1) begin
            if (idx == k[`CHAN_IDX_W-1:0]) begin
               onehot[k] = 1'b1;
            end
         end
      end
   endfunction

   function is_chan_res;
      input [`ADDR_W-1:0] a;
      begin
         is_chan_res = (a[7:5] == `CHAN_RES_HI) && (a[1:0] == 2'b00);
      end
   endfunction

   // ****************************************************************
   // declarations
   // ****************************************************************
   reg  [`NUM_CHAN-1:0]          chan_en_q;
   reg  [`NUM_CHAN-1:0]          chan_en_d;
   reg                           mode_sleep_q;
   reg  [`IRQ_W-1:0]             irq_en_q;
   reg  [`RESULT_W-1:0]          last_result_q;
   reg  [`CHAN_IDX_W-1:0]        last_chan_q;
   reg  [`DATA_W-1:0]            rd_mux;
   reg                           sleep_d;

   wire [`NUM_CHAN*`RESULT_W-1:0] chan_result_flat;
   wire [`NUM_CHAN-1:0]          end_hot;
   wire [`NUM_CHAN-1:0]          rd_chan_hot;
   wire [`NUM_CHAN-1:0]          done_q;
   wire [`NUM_CHAN-1:0]          done_set;
   wire [`NUM_CHAN-1:0]          done_clr;
   wire [`NUM_CHAN-1:0]          ovr_q;
   wire [`NUM_CHAN-1:0]          ovr_set;
   wire                          valid_end;
   wire                          rd_status;
   wire                          rd_last;
   wire                          rdy_q;
   wire                          rdy_set;
   wire                          govr_q;
   wire                          govr_set;
   wire [`IRQ_W-1:0]             irq_set;
   wire [`IRQ_W-1:0]             irq_clr;
   wire [`IRQ_W-1:0]             irq_stat_q;
   wire                          wr_irq_clear;

   // ****************************************************************
   // event and strobe decode
   // ****************************************************************
   // an end on a disabled channel, including one disabled mid-conversion, sets no flag or result; only sleep entry still sees it
   assign end_hot     = conv_end ? (onehot(conv_chan) & chan_en_q) : {`NUM_CHAN{1'b0}};
   assign valid_end   = |end_hot;
   assign rd_status   = reg_rd && (reg_addr == `REG_STATUS);
   assign rd_last     = reg_rd && (reg_addr == `REG_LAST_RESULT);
   assign rd_chan_hot = (reg_rd && is_chan_res(reg_addr)) ? onehot(reg_addr[4:2])
                                                          : {`NUM_CHAN{1'b0}};
   assign wr_irq_clear = reg_wr && (reg_addr == `REG_IRQ_CLEAR);

   // ****************************************************************
   // per-channel flags and results
   // ****************************************************************
   genvar gi;
   generate
      for (gi = 0; gi < `NUM_CHAN; gi = gi + 1) begin : g_chan
         reg [`RESULT_W-1:0] result_q;

         assign done_set[gi] = end_hot[gi];
         // only this channel's own read, or a last-result read of its data
         assign done_clr[gi] = rd_chan_hot[gi] |
                               (rd_last && (last_chan_q == gi));
         assign ovr_set[gi]  = end_hot[gi] & done_q[gi];

         always @(posedge ref_clk or posedge rst) begin
            if (rst) begin
               result_q <= `RESULT_RST;
            end else if (end_hot[gi]) begin
               result_q <= conv_data;
            end
         end

         assign chan_result_flat[gi*`RESULT_W +: `RESULT_W] = result_q;

         sticky_flag u_done (
            .ref_clk (ref_clk),
            .rst     (rst),
            .set     (done_set[gi]),
            .clr     (done_clr[gi]),
            .flag_q  (done_q[gi])
         );

         // status read clears, a fresh overrun in the same cycle survives
         sticky_flag u_ovr (
            .ref_clk (ref_clk),
            .rst     (rst),
            .set     (ovr_set[gi]),
            .clr     (rd_status),
            .flag_q  (ovr_q[gi])
         );
      end
   endgenerate

   // ****************************************************************
   // global flags
   // ****************************************************************
   assign rdy_set  = valid_end;
   assign govr_set = valid_end & rdy_q;

   // channel result reads have no path to this clear
   sticky_flag u_rdy (
      .ref_clk (ref_clk),
      .rst     (rst),
      .set     (rdy_set),
      .clr     (rd_last),
      .flag_q  (rdy_q)
   );

   sticky_flag u_govr (
      .ref_clk (ref_clk),
      .rst     (rst),
      .set     (govr_set),
      .clr     (rd_status),
      .flag_q  (govr_q)
   );

   // ****************************************************************
   // last result
   // ****************************************************************
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         last_result_q <= `RESULT_RST;
         last_chan_q   <= {`CHAN_IDX_W{1'b0}};
      end else if (valid_end) begin
         last_result_q <= conv_data;
         last_chan_q   <= conv_chan;
      end
   end

   // ****************************************************************
   // interrupt status
   // ****************************************************************
   assign irq_set = {govr_set, |ovr_set, rdy_set, done_set};
   assign irq_clr = wr_irq_clear ? reg_wdata[`IRQ_W-1:0] : {`IRQ_W{1'b0}};

   generate
      for (gi = 0; gi < `IRQ_W; gi = gi + 1) begin : g_irq
         sticky_flag u_irq (
            .ref_clk (ref_clk),
            .rst     (rst),
            .set     (irq_set[gi]),
            .clr     (irq_clr[gi]),
            .flag_q  (irq_stat_q[gi])
         );
      end
   endgenerate

   assign irq = |(irq_stat_q & irq_en_q);

   // ****************************************************************
   // control registers
   // ****************************************************************
   always @* begin
      chan_en_d = chan_en_q;
      if (reg_wr && (reg_addr == `REG_CHAN_ENABLE)) begin
         chan_en_d = chan_en_q | reg_wdata[`NUM_CHAN-1:0];
      end
      if (reg_wr && (reg_addr == `REG_CHAN_DISABLE)) begin
         chan_en_d = chan_en_q & ~reg_wdata[`NUM_CHAN-1:0];
      end
   end

   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         chan_en_q    <= `CHAN_EN_RST;
         mode_sleep_q <= `MODE_RST;
         irq_en_q     <= `IRQ_EN_RST;
         conv_start   <= 1'b0;
      end else begin
         chan_en_q  <= chan_en_d;
         conv_start <= reg_wr && (reg_addr == `REG_CONTROL) &&
                       reg_wdata[`CTRL_START_BIT];
         if (reg_wr && (reg_addr == `REG_MODE)) begin
            mode_sleep_q <= reg_wdata[`MODE_SLEEP_BIT];
         end
         if (reg_wr && (reg_addr == `REG_IRQ_ENABLE)) begin
            irq_en_q <= reg_wdata[`IRQ_W-1:0];
         end
      end
   end

   assign chan_enable = chan_en_q;

   // ****************************************************************
   // sleep entry
   // ****************************************************************
   // selecting sleep arms it; the converter only drops into sleep at an end
   always @* begin
      sleep_d = mode_sleep_q & (sleep_active | conv_end);
   end

   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         sleep_active <= 1'b0;
      end else begin
         sleep_active <= sleep_d;
      end
   end

   // ****************************************************************
   // read path
   // ****************************************************************
   always @* begin
      rd_mux = `RDATA_RST;
      if (is_chan_res(reg_addr)) begin
         rd_mux[`RESULT_W-1:0] = chan_result_flat[reg_addr[4:2]*`RESULT_W +: `RESULT_W];
      end else begin
         case (reg_addr)
            `REG_MODE: begin
               rd_mux[`MODE_SLEEP_BIT] = mode_sleep_q;
            end
            `REG_CHAN_STATUS: begin
               rd_mux[`NUM_CHAN-1:0] = chan_en_q;
            end
            `REG_STATUS: begin
               rd_mux[`ST_DONE_LSB +: `NUM_CHAN] = done_q;
               rd_mux[`ST_OVR_LSB +: `NUM_CHAN]  = ovr_q;
               rd_mux[`ST_RDY_BIT]               = rdy_q;
               rd_mux[`ST_GOVR_BIT]              = govr_q;
            end
            `REG_LAST_RESULT: begin
               rd_mux[`RESULT_W-1:0]                    = last_result_q;
               rd_mux[`LAST_CHAN_LSB +: `CHAN_IDX_W]    = last_chan_q;
            end
            `REG_IRQ_ENABLE: begin
               rd_mux[`IRQ_W-1:0] = irq_en_q;
            end
            `REG_IRQ_STATUS: begin
               rd_mux[`IRQ_W-1:0] = irq_stat_q;
            end
            default: begin
               rd_mux = `RDATA_RST;
            end
         endcase
      end
   end

   // data stands only in the cycle after the strobe
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         reg_rdata <= `RDATA_RST;
      end else if (reg_rd) begin
         reg_rdata <= rd_mux;
      end else begin
         reg_rdata <= `RDATA_RST;
      end
   end

endmodule

// ### dv/adc_flag_asserts.sv
// Purpose: port-level checks of the converter flag logic
// Assumes: one clock ref_clk, asynchronous active-high rst
// Notes:   bound to adc_status_flag_logic from the tb top file
`timescale 1ns/100ps
`include "adc_flag_consts.vh"
module adc_flag_asserts (
   // clock and reset
   input wire                   ref_clk,
   input wire                   rst,
   // register port
   input wire [`ADDR_W-1:0]     reg_addr,
   input wire [`DATA_W-1:0]     reg_wdata,
   input wire                   reg_wr,
   input wire                   reg_rd,
   input wire [`DATA_W-1:0]     reg_rdata,
   // conversion core
   input wire                   conv_end,
   input wire [`CHAN_IDX_W-1:0] conv_chan,
   input wire [`RESULT_W-1:0]   conv_data,
   input wire                   conv_start,
   input wire [`NUM_CHAN-1:0]   chan_enable,
   // power and interrupt
   input wire                   sleep_active,
   input wire                   irq
);
   default clocking @(posedge ref_clk);
   endclocking
   default disable iff (rst);
   // ****************************************************************
   // sequences
   // ****************************************************************
   sequence s_st_rd;
      reg_rd && reg_addr == `REG_STATUS;
   endsequence
   sequence s_en_end;
      conv_end && chan_enable[conv_chan];
   endsequence
   // ****************************************************************
   // properties
   // ****************************************************************
   a_start_pulse: assert property ((reg_wr && reg_addr == `REG_CONTROL && reg_wdata[0])
      |=> conv_start) else $error("start pulse missing");
   a_store_last: assert property (s_en_end ##1 (reg_rd && reg_addr == `REG_LAST_RESULT)
      |=> reg_rdata[9:0] == $past(conv_data, 2) && reg_rdata[14:12] == $past(conv_chan, 2))
      else $error("last result not stored");
   a_ready_set: assert property (s_en_end ##1 s_st_rd |=> reg_rdata[16])
      else $error("data ready not set");
   a_ready_keep: assert property (s_st_rd ##1 (reg_rdata[16] && reg_rd
      && reg_addr[7:5] == `CHAN_RES_HI) ##1 s_st_rd |=> reg_rdata[16])
      else $error("data ready lost on channel read");
   a_ready_clear: assert property ((reg_rd && reg_addr == `REG_LAST_RESULT && !conv_end)
      ##1 s_st_rd |=> !reg_rdata[16]) else $error("data ready kept after last read");
   a_govr_set: assert property (s_st_rd ##1 (reg_rdata[16] && conv_end
      && chan_enable[conv_chan]) ##1 s_st_rd |=> reg_rdata[17])
      else $error("global overrun not set");
   a_ovr_set: assert property (s_st_rd ##1 (conv_end && chan_enable[conv_chan]
      && reg_rdata[conv_chan]) ##1 s_st_rd |=> reg_rdata[8 + $past(conv_chan, 2)])
      else $error("channel overrun not set");
   a_status_clr: assert property ((reg_rd && reg_addr == `REG_STATUS && !conv_end)
      ##1 s_st_rd |=> {reg_rdata[17], reg_rdata[15:8]} == 9'h000)
      else $error("overrun flags survive status read");
   a_sleep_cause: assert property ($rose(sleep_active)
      |-> $past(conv_end) || $past(conv_end, 2)) else $error("sleep without conversion end");
   a_enable_set: assert property ((reg_wr && reg_addr == `REG_CHAN_ENABLE)
      |=> (chan_enable & $past(reg_wdata[7:0])) == $past(reg_wdata[7:0]))
      else $error("channel enable not set");
endmodule

// ### dv/tb.sv
// Purpose: self-checking bench of the converter flag logic
// Assumes: 20 MHz ref_clk, bench drives every input except ref_clk by non-blocking assignment
// Notes:   rdata_seen holds the answer to the read of the previous step
`timescale 1ns/100ps
`include "adc_flag_consts.vh"
module tb;
   logic        ref_clk = 1'b0;
   logic        rst = 1'b1;
   logic [7:0]  reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0000_0000;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic        conv_end = 1'b0;
   logic [2:0]  conv_chan = 3'h0;
   logic [9:0]  conv_data = 10'h000;
   wire  [31:0] reg_rdata;
   wire         conv_start;
   wire  [7:0]  chan_enable;
   wire         sleep_active;
   wire         irq;
   logic [31:0] rdata_seen;
   int          err_total = 0;
   int          comparisons = 0;
   adc_status_flag_logic u_dut (
      .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .conv_end(conv_end),
      .conv_chan(conv_chan), .conv_data(conv_data), .conv_start(conv_start),
      .chan_enable(chan_enable), .sleep_active(sleep_active), .irq(irq));
   always #25 ref_clk = ~ref_clk;
   // ****************************************************************
   // drivers and comparison
   // ****************************************************************
   task automatic step(input logic r, w, input logic [7:0] a, input logic [31:0] d,
                       input logic e, input logic [2:0] c, input logic [9:0] x);
      @(posedge ref_clk);
      reg_rd <= r;
      reg_wr <= w;
      reg_addr <= a;
      reg_wdata <= d;
      conv_end <= e;
      conv_chan <= c;
      conv_data <= x;
      #1 rdata_seen = reg_rdata;
   endtask
   task automatic rd(input logic [7:0] a);
      step(1, 0, a, 0, 0, 0, 0);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      step(0, 1, a, d, 0, 0, 0);
   endtask
   task automatic cend(input logic [2:0] c, input logic [9:0] x);
      step(0, 0, 0, 0, 1, c, x);
   endtask
   task automatic idle;
      step(0, 0, 0, 0, 0, 0, 0);
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic tally_and_finish;
      if (err_total == 0 && comparisons > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // ****************************************************************
   // scenarios
   // ****************************************************************
   task automatic t_reset;
      rd(`REG_STATUS);
      rd(`REG_MODE);
      chk(rdata_seen, 32'h0000_0000);
      rd(`REG_IRQ_ENABLE);
      chk(rdata_seen, 32'h0000_0000);
      rd(8'h3c);
      chk(rdata_seen, 32'h0000_0000);
      wr(`REG_STATUS, 32'hffff_ffff);
      chk(rdata_seen, 32'h0000_0000);
      rd(`REG_STATUS);
      idle;
      chk(rdata_seen, 32'h0000_0000);
      chk(chan_enable, 32'h0000_0000);
   endtask
   task automatic t_flags;
      wr(`REG_CHAN_ENABLE, 32'h0000_00ff);
      cend(3'h2, 10'h155);
      chk(chan_enable, 32'h0000_00ff);
      cend(3'h5, 10'h2aa);
      step(1, 0, 8'h48, 0, 1, 3'h6, 10'h0f0);
      rd(`REG_STATUS);
      chk(rdata_seen, 32'h0000_0155);
      rd(`REG_LAST_RESULT);
      chk(rdata_seen, 32'h0003_0060);
      rd(`REG_STATUS);
      chk(rdata_seen, 32'h0000_60f0);
      cend(3'h5, 10'h3ff);
      chk(rdata_seen, 32'h0000_0020);
      rd(8'h54);
      step(1, 0, `REG_STATUS, 0, 1, 3'h5, 10'h001);
      chk(rdata_seen, 32'h0000_03ff);
      rd(`REG_STATUS);
      chk(rdata_seen, 32'h0001_2000);
      wr(`REG_CHAN_DISABLE, 32'h0000_0080);
      chk(rdata_seen, 32'h0003_0020);
      cend(3'h7, 10'h123);
      rd(`REG_CHAN_STATUS);
      rd(`REG_LAST_RESULT);
      chk(rdata_seen, 32'h0000_007f);
      rd(`REG_STATUS);
      chk(rdata_seen, 32'h0000_5001);
      idle;
      chk(rdata_seen, 32'h0000_0000);
   endtask
   // own-channel read meets an end on that channel while done and ready stand
   task automatic t_overrun;
      cend(3'h3, 10'h0a5);
      rd(`REG_STATUS);
      step(1, 0, 8'h4c, 0, 1, 3'h3, 10'h15a);
      chk(rdata_seen, 32'h0001_0008);
      rd(`REG_STATUS);
      chk(rdata_seen, 32'h0000_00a5);
      rd(`REG_STATUS);
      chk(rdata_seen, 32'h0003_0808);
      rd(`REG_LAST_RESULT);
      chk(rdata_seen, 32'h0001_0008);
      rd(`REG_STATUS);
      chk(rdata_seen, 32'h0000_315a);
      idle;
      chk(rdata_seen, 32'h0000_0000);
   endtask
   task automatic t_irq;
      wr(`REG_IRQ_CLEAR, 32'h0000_07ff);
      wr(`REG_IRQ_ENABLE, 32'h0000_0100);
      idle;
      chk(irq, 32'h0000_0000);
      cend(3'h1, 10'h011);
      idle;
      chk(irq, 32'h0000_0001);
      wr(`REG_IRQ_ENABLE, 32'h0000_0000);
      idle;
      chk(irq, 32'h0000_0000);
      wr(`REG_IRQ_ENABLE, 32'h0000_0100);
      wr(`REG_IRQ_CLEAR, 32'h0000_0100);
      chk(irq, 32'h0000_0001);
      idle;
      chk(irq, 32'h0000_0000);
      rd(`REG_IRQ_STATUS);
      rd(`REG_IRQ_ENABLE);
      chk(rdata_seen, 32'h0000_0002);
      idle;
      chk(rdata_seen, 32'h0000_0100);
   endtask
   task automatic t_sleep;
      wr(`REG_MODE, 32'h0000_0001);
      idle;
      idle;
      chk(sleep_active, 32'h0000_0000);
      wr(`REG_CONTROL, 32'h0000_0001);
      idle;
      chk(conv_start, 32'h0000_0001);
      idle;
      chk(conv_start, 32'h0000_0000);
      cend(3'h0, 10'h200);
      idle;
      idle;
      chk(sleep_active, 32'h0000_0001);
      wr(`REG_MODE, 32'h0000_0000);
      idle;
      idle;
      chk(sleep_active, 32'h0000_0000);
   endtask
   initial begin
      repeat (8) @(posedge ref_clk);
      rst <= 1'b0;
      t_reset;
      t_flags;
      t_overrun;
      t_irq;
      t_sleep;
      tally_and_finish;
   end
   initial begin
      #100000;
      err_total++;
      tally_and_finish;
   end
endmodule
bind adc_status_flag_logic adc_flag_asserts u_chk (
   .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .conv_end(conv_end),
   .conv_chan(conv_chan), .conv_data(conv_data), .conv_start(conv_start),
   .chan_enable(chan_enable), .sleep_active(sleep_active), .irq(irq));
